// [src/secg_pin_sync.sv]
// three-stage synchroniser for a level arriving from a pin
// assumes the level is slow compared with the system clock
`timescale 1ns/1ps
module secg_pin_sync
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// pin and result
	input wire logic pin_i,
	output logic level_o
);
	logic [2:0] stage_ff;

	// shift chain; first stage is read only by the second
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			stage_ff <= 3'h0;
		else
			stage_ff <= {stage_ff[1:0], pin_i};
	end

	// accept a change only once stages two and three agree
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			level_o <= 1'b0;
		else if (stage_ff[1] == stage_ff[2])
			level_o <= stage_ff[2];
	end
endmodule

// [src/secg_pkg.sv]
// package for the serializer external clock generator
// assumes a single system clock; all generated clocks are divided copies of it
package secg_pkg;

	// ----------------------------------------
	// timing and structure
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 4000; // system clock period, 250 MHz
	localparam int unsigned SER_FACTOR_DEF = 8; // serialization factor default
	localparam int unsigned BIT_DIV_DEF = 2; // system cycles per serial bit, even
	localparam int unsigned LOCK_WAIT_NS = 1000; // time from enable to lock
	localparam int unsigned LOCK_WAIT_CYC = (LOCK_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SYNC_DEPTH = 3; // pin input synchroniser depth

	// ----------------------------------------
	// carried bundles
	// ----------------------------------------
	typedef struct packed {
		logic fast_serial_clock; // serial-rate clock
		logic load_enable; // load pulse, one per word
		logic parallel_word_clock; // word-rate clock
	} secg_clocks_type;

	typedef enum logic [1:0] {
		SECG_IDLE,
		SECG_LOCKING,
		SECG_LOCKED
	} secg_state_type;

endpackage

// [src/secg_top.sv]
// external clock generator for a serializer/deserializer pair
// assumes the fabric uses only the word clock; the serial clock goes to serializers only
`timescale 1ns/1ps

module secg_top
#(
	parameter int unsigned SER_FACTOR = secg_pkg::SER_FACTOR_DEF,
	parameter int unsigned BIT_DIV = secg_pkg::BIT_DIV_DEF,
	parameter int unsigned LOCK_WAIT = secg_pkg::LOCK_WAIT_CYC
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// control pins
	input wire logic gen_enable_i,
	input wire logic dynamic_phase_alignment_i,
	// generated clocks
	output logic fast_serial_clock_out_o,
	output logic load_enable_out_o,
	output logic parallel_word_clock_out_o,
	// lock, receiver reset and mode fault
	output logic locked_o,
	output logic rx_synth_reset_o,
	output logic mode_fault_o
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (SER_FACTOR < 3 || SER_FACTOR > 10 || (SER_FACTOR % 2) != 0)
		$error("SER_FACTOR must be even, 4 to 10");
	if (BIT_DIV < 2 || (BIT_DIV % 2) != 0)
		$error("BIT_DIV must be even and at least 2");
	if (LOCK_WAIT < 1)
		$error("LOCK_WAIT must be at least 1");

	localparam int unsigned WORD_DIV = SER_FACTOR * BIT_DIV;
	localparam int unsigned PW = $clog2(WORD_DIV);
	localparam int unsigned LW = $clog2(LOCK_WAIT + 1);
	localparam logic [PW-1:0] WORD_LAST = PW'(WORD_DIV - 1);
	localparam logic [PW-1:0] HALF_BIT = PW'(BIT_DIV / 2);
	// load window starts (factor-2)/factor of a word in, lasts one bit
	localparam logic [PW-1:0] LOAD_START = PW'((SER_FACTOR - 2) * BIT_DIV);
	// word clock lags by half a bit: -180/factor of a word
	localparam logic [PW-1:0] WORD_RISE = PW'(BIT_DIV / 2);
	localparam logic [PW-1:0] WORD_FALL = PW'(BIT_DIV / 2 + WORD_DIV / 2);
	localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_WAIT);
	// phase map at factor 8 with two cycles a bit, sixteen cycles a word:
	//   serial clock high on odd phases
	//   load window on phases 12 and 13
	//   word clock high on phases 1 to 8
	// a stop clears the counter, so every start gives the same output relation

	// ----------------------------------------
	// pin inputs
	// ----------------------------------------
	// both pins are levels from outside the clock domain, each gets its own chain
	logic enable_sync;
	logic dpa_sync;

	secg_pin_sync u_sync_en
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.pin_i(gen_enable_i),
		.level_o(enable_sync)
	);

	secg_pin_sync u_sync_dpa
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.pin_i(dynamic_phase_alignment_i),
		.level_o(dpa_sync)
	);

	// ----------------------------------------
	// lock sequencing
	// ----------------------------------------
	secg_pkg::secg_state_type state_ff;
	secg_pkg::secg_state_type nxt_state;
	logic [LW-1:0] lock_cnt_ff;

	// lock asserts only after the dividers have run a settle time
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			secg_pkg::SECG_IDLE:
				if (enable_sync)
					nxt_state = secg_pkg::SECG_LOCKING;
			secg_pkg::SECG_LOCKING:
				if (!enable_sync)
					nxt_state = secg_pkg::SECG_IDLE;
				else if (lock_cnt_ff == LOCK_LAST)
					nxt_state = secg_pkg::SECG_LOCKED;
			secg_pkg::SECG_LOCKED:
				if (!enable_sync)
					nxt_state = secg_pkg::SECG_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			state_ff <= secg_pkg::SECG_IDLE;
		else
			state_ff <= nxt_state;
	end

	// settle counter, cleared outside the locking state
	// it stops at the limit, so a long stay in the locking state cannot wrap
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i || state_ff != secg_pkg::SECG_LOCKING)
			lock_cnt_ff <= '0;
		else if (lock_cnt_ff != LOCK_LAST)
			lock_cnt_ff <= lock_cnt_ff + LW'(1);
	end

	// ----------------------------------------
	// common phase counter
	// ----------------------------------------
	logic [PW-1:0] phase_ff;
	logic running;

	assign running = (state_ff != secg_pkg::SECG_IDLE);

	// one counter times all three outputs, so they never drift apart
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i || !running)
			phase_ff <= '0;
		else if (phase_ff == WORD_LAST)
			phase_ff <= '0;
		else
			phase_ff <= phase_ff + PW'(1);
	end

	// position within the current bit
	function automatic logic [PW-1:0] bit_pos(input logic [PW-1:0] p);
		bit_pos = PW'(p % PW'(BIT_DIV));
	endfunction

	// ----------------------------------------
	// clock outputs
	// ----------------------------------------
	secg_pkg::secg_clocks_type clk_ff;
	secg_pkg::secg_clocks_type nxt_clk;
	logic [PW-1:0] nxt_phase;

	// decode one cycle early so the registered outputs land on phase
	always_comb
	begin
		nxt_phase = (phase_ff == WORD_LAST || !running) ? '0 : phase_ff + PW'(1);
		nxt_clk = '0;
		if (running)
		begin
			// bit rate, 50% duty, high in second half of bit: -180 deg
			nxt_clk.fast_serial_clock = (bit_pos(nxt_phase) >= HALF_BIT);
			// one bit wide, word rate, starts at (factor-2)/factor
			nxt_clk.load_enable = (nxt_phase >= LOAD_START) && (nxt_phase < LOAD_START + PW'(BIT_DIV));
			// word rate, 50% duty, shifted half a bit
			nxt_clk.parallel_word_clock = (nxt_phase >= WORD_RISE) && (nxt_phase < WORD_FALL);
		end
	end

	// outputs stay low while idle; drive serializer and fabric ports
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			clk_ff <= '0;
		else
			clk_ff <= nxt_clk;
	end

	assign fast_serial_clock_out_o = clk_ff.fast_serial_clock;
	assign load_enable_out_o = clk_ff.load_enable;
	assign parallel_word_clock_out_o = clk_ff.parallel_word_clock;

	// ----------------------------------------
	// lock, receiver reset and mode fault
	// ----------------------------------------
	// a single reset output, receiver only; none exists for the transmitter
	// lock and reset share one decode of the next state, so they never disagree
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			locked_o <= 1'b0;
			rx_synth_reset_o <= 1'b1;
		end
		else
		begin
			locked_o <= (nxt_state == secg_pkg::SECG_LOCKED);
			rx_synth_reset_o <= !(nxt_state == secg_pkg::SECG_LOCKED);
		end
	end

	// phase settings above do not suit alignment modes; flag the misuse
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			mode_fault_o <= 1'b0;
		else
			mode_fault_o <= dpa_sync && running;
	end
endmodule

// [tb/secg_fabric_model.sv]
// far side: serializer pair and fabric word registers, as edge counters
// assumes clocks are sampled by the system clock, not used as clocks
`timescale 1ns/1ps
module secg_fabric_model
(
	// clock
	input wire logic clk_sys_i,
	// generated clocks, in the bundle's field order: serial, load, word
	input wire secg_pkg::secg_clocks_type clks_i,
	// observed counts
	output int bit_cnt_o,
	output int load_cnt_o,
	output int word_cnt_o
);
	secg_pkg::secg_clocks_type last_ff;
	// rx reset is left unused here rx serial and load inputs stay unconnected
	// edge-aligned setup only; other phase relations take settings from an internal-source build
	always_ff @(posedge clk_sys_i)
	begin
		last_ff <= clks_i;
		bit_cnt_o <= bit_cnt_o + int'(clks_i.fast_serial_clock && !last_ff.fast_serial_clock);
		load_cnt_o <= load_cnt_o + int'(clks_i.load_enable && !last_ff.load_enable);
		word_cnt_o <= word_cnt_o + int'(clks_i.parallel_word_clock && !last_ff.parallel_word_clock);
	end
endmodule

// [tb/secg_props.sv]
// checker: shape and timing of the generated clocks and of lock
// assumes factor 8 and two cycles per bit, so the repeat counts are fixed
`timescale 1ns/1ps
module secg_props
#(
	parameter int unsigned SER_FACTOR = 8,
	parameter int unsigned BIT_DIV = 2,
	parameter int unsigned LOCK_WAIT = 4
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// control pins
	input wire logic gen_enable_i,
	input wire logic dynamic_phase_alignment_i,
	// generated clocks, lock, receiver reset and mode fault
	input wire logic fast_serial_clock_out_o,
	input wire logic load_enable_out_o,
	input wire logic parallel_word_clock_out_o,
	input wire logic locked_o,
	input wire logic rx_synth_reset_o,
	input wire logic mode_fault_o
);
	localparam int WORD_CYC = SER_FACTOR * BIT_DIV;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	// clock shape is judged only while locked, since stopping may cut a pulse
	sequence s_load_pulse;
		load_enable_out_o [*2] ##1 !load_enable_out_o;
	endsequence
	sequence s_word_high;
		parallel_word_clock_out_o [*8] ##1 !parallel_word_clock_out_o;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_RX_RESET_INV: assert property (rx_synth_reset_o == !locked_o)
		else $error("rx reset not inverse of lock");
	AST_SERIAL_TOGGLE: assert property (disable iff (srst_i || !locked_o)
		$past(locked_o) |-> fast_serial_clock_out_o != $past(fast_serial_clock_out_o))
		else $error("serial clock not toggling");
	AST_LOAD_WIDTH: assert property (disable iff (srst_i || !locked_o)
		$rose(load_enable_out_o) |-> s_load_pulse)
		else $error("load pulse width wrong");
	AST_LOAD_PERIOD: assert property (disable iff (srst_i || !locked_o)
		$rose(load_enable_out_o) |-> ##WORD_CYC $rose(load_enable_out_o))
		else $error("load period wrong");
	AST_WORD_HIGH: assert property (disable iff (srst_i || !locked_o)
		$rose(parallel_word_clock_out_o) |-> s_word_high)
		else $error("word clock high time wrong");
	AST_WORD_PHASE: assert property (disable iff (srst_i || !locked_o)
		$fell(load_enable_out_o) |-> ##3 ($rose(parallel_word_clock_out_o) && fast_serial_clock_out_o))
		else $error("word clock phase wrong");
	AST_LOCK_DROP: assert property (!gen_enable_i [*8] |-> !locked_o && !load_enable_out_o
		&& !parallel_word_clock_out_o && !fast_serial_clock_out_o)
		else $error("outputs alive while disabled");
	AST_LOCK_WAIT: assert property (!gen_enable_i [*8] ##1 gen_enable_i |-> !locked_o [*8])
		else $error("lock too early");
endmodule

bind secg_top secg_props #(.SER_FACTOR(SER_FACTOR), .BIT_DIV(BIT_DIV), .LOCK_WAIT(LOCK_WAIT)) u_props
(
	.clk_sys_i(clk_sys_i),
	.srst_i(srst_i),
	.gen_enable_i(gen_enable_i),
	.dynamic_phase_alignment_i(dynamic_phase_alignment_i),
	.fast_serial_clock_out_o(fast_serial_clock_out_o),
	.load_enable_out_o(load_enable_out_o),
	.parallel_word_clock_out_o(parallel_word_clock_out_o),
	.locked_o(locked_o),
	.rx_synth_reset_o(rx_synth_reset_o),
	.mode_fault_o(mode_fault_o)
);

// [tb/tb_secg_top.sv]
// bench: lock, fault, reset and clock counts of the generator
// assumes the lock wait is shortened to 4 cycles
`timescale 1ns/1ps
module tb_secg_top;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic en = 1'b0;
	logic dynamic_phase_alignment = 1'b0;
	logic ser, lde, wrd, lck, rxr, flt;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int b0, l0, w0, bc, lc, wc;
	secg_pkg::secg_clocks_type clks;
	// rows: enable, alignment, expected locked, expected fault
	logic [3:0] rows [4] = '{4'ha, 4'hf, 4'ha, 4'h4};
	assign clks = {ser, lde, wrd};
	secg_top #(.LOCK_WAIT(4)) u_dut
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.gen_enable_i(en),
		.dynamic_phase_alignment_i(dynamic_phase_alignment),
		.fast_serial_clock_out_o(ser),
		.load_enable_out_o(lde),
		.parallel_word_clock_out_o(wrd),
		.locked_o(lck),
		.rx_synth_reset_o(rxr),
		.mode_fault_o(flt)
	);
	secg_fabric_model u_far
	(
		.clk_sys_i(clk_sys_i),
		.clks_i(clks),
		.bit_cnt_o(bc),
		.load_cnt_o(lc),
		.word_cnt_o(wc)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// free-running system clock
	initial
	begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	// main sequence; samples 1 ns after an edge so registered outputs have landed
	initial
	begin
		tick(9);
		#1;
		check("rx reset in reset", rxr, 1'b1);
		$display("reset hold test done");
		@(posedge clk_sys_i);
		srst_i <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge clk_sys_i);
			en <= rows[i][3];
			dynamic_phase_alignment <= rows[i][2];
			tick(40);
			#1;
			check("locked", lck, rows[i][1]);
			check("rx reset", rxr, !rows[i][1]);
			check("mode fault", flt, rows[i][0]);
			$display("row %0d done", i);
		end
		// a whole number of words while locked gives exact counts
		@(posedge clk_sys_i);
		en <= 1'b1;
		tick(40);
		b0 = bc;
		l0 = lc;
		w0 = wc;
		tick(64);
		check("serial bits", bc - b0, 32);
		check("load pulses", lc - l0, 4);
		check("words", wc - w0, 4);
		$display("count test done");
		// mid-run reset, then lock must wait again
		srst_i <= 1'b1;
		tick(2);
		#1;
		check("locked in reset", lck, 1'b0);
		check("serial in reset", ser, 1'b0);
		@(posedge clk_sys_i);
		srst_i <= 1'b0;
		tick(6);
		#1;
		check("early lock", lck, 1'b0);
		tick(30);
		#1;
		check("relock", lck, 1'b1);
		$display("reset test done");
		give_verdict();
	end
endmodule
